// [logic/canain_node.sv]
`timescale 1ns/100ps
module canain_node
  import canain_pkg::*;
#(
  parameter longint BOOT_CYC = BOOT_WAIT_CYC
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // board straps and reset cause
  input  wire logic [5:0]        station_number,
  input  wire logic [7:0]        reset_cause_register,
  // avalon-mm slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // received frames
  input  wire canain_frame_type  rx_frame,
  // frames to transmit
  output canain_frame_type       tx_frame,
  input  wire logic              tx_ready,
  // adc conversion
  output logic                   adc_start,
  output logic      [5:0]        adc_chan,
  input  wire canain_sample_type adc_sample
);
  typedef enum {ST_BOOT, ST_EMCY, ST_WAIT, ST_BOOTUP, ST_PREOP, ST_OPER} canain_state_type;
  typedef enum {SC_IDLE, SC_CONV, SC_WAIT, SC_SEND} canain_scan_type;

  canain_state_type state_r;
  canain_scan_type  scan_r;
  logic [63:0] boot_cnt_r;
  logic        cold_r;       // low until the first power-up hand-over is done
  logic [5:0]  station_r;
  logic [5:0]  stn_s1_r, stn_s2_r, stn_s3_r; // switch synchroniser stages
  logic        autostart_r;
  logic [6:0]  adccfg_r;
  logic [6:0]  chan_cnt_r;
  logic [7:0]  txcnt_r, txuv_r, defcnt_r, defuv_r;
  logic [7:0]  calvalid_r;
  logic [31:0] calgain_r;
  logic [5:0]  chan_r;
  logic [15:0] count_r;
  logic        err_r;
  logic        ack_r;
  logic        soft_rst;
  logic        nmt_hit, nmt_start, nmt_reset, sync_hit;
  logic        use_uv;
  logic [31:0] uv_val;
  logic [7:0]  status_byte;

  // frames addressed to this node or to all
  assign nmt_hit   = rx_frame.valid && rx_frame.id == ID_NMT
                     && (rx_frame.data[55:48] == 8'h00
                         || rx_frame.data[55:48] == {2'b00, station_r});
  assign nmt_start = nmt_hit && rx_frame.data[63:56] == NMT_START;
  assign nmt_reset = nmt_hit && rx_frame.data[63:56] == NMT_RESET;
  assign sync_hit  = rx_frame.valid && rx_frame.id == ID_SYNC && rx_frame.dlc == 4'h0;
  assign soft_rst  = avs_write && avs_address == OFF_CTRL && ack_r
                     && avs_writedata[CTRL_SOFTRST_BIT];

  // one wait state per access: answer on the second edge
  always_ff @(posedge core_clk) begin
    if (reset) ack_r <= 1'b0;
    else ack_r <= (avs_read || avs_write) && !ack_r;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  // register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      autostart_r <= 1'b0;
      adccfg_r    <= ADCCFG_RST;
      chan_cnt_r  <= CHAN_CNT_RST;
      defcnt_r    <= TXTYPE_RST;
      defuv_r     <= TXTYPE_RST;
      calvalid_r  <= 8'h00;
      calgain_r   <= 32'h0000_0001;
    end else if (avs_write && ack_r) begin
      if (avs_address == OFF_CTRL) begin
        autostart_r <= avs_writedata[CTRL_AUTOSTART_BIT];
      end else if (avs_address == OFF_ADCCFG) begin
        adccfg_r <= avs_writedata[6:0];
        chan_cnt_r <= (avs_writedata[14:8] > CHAN_CNT_RST) ? CHAN_CNT_RST
                                                           : avs_writedata[14:8];
      end else if (avs_address == OFF_CALVALID) begin
        calvalid_r <= avs_writedata[7:0];
      end else if (avs_address == OFF_CALGAIN) begin
        calgain_r <= avs_writedata;
      end else if (avs_address == OFF_DEFTX) begin
        defcnt_r <= avs_writedata[7:0];
        defuv_r  <= avs_writedata[15:8];
      end
    end
  end

  // live types, reloaded from saved defaults on any reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txcnt_r <= TXTYPE_RST;
      txuv_r  <= TXTYPE_RST;
    end else if (state_r == ST_BOOTUP) begin
      txcnt_r <= defcnt_r;
      txuv_r  <= defuv_r;
    end else if (avs_write && ack_r && avs_address == OFF_TXTYPE) begin
      txcnt_r <= avs_writedata[7:0];
      txuv_r  <= avs_writedata[15:8];
    end
  end

  // register reads; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (reset) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_r) begin
      if (avs_address == OFF_CTRL) avs_readdata <= {31'h0, autostart_r};
      else if (avs_address == OFF_ADCCFG) avs_readdata <= {17'h0, chan_cnt_r, 1'b0, adccfg_r};
      else if (avs_address == OFF_TXTYPE) avs_readdata <= {16'h0, txuv_r, txcnt_r};
      else if (avs_address == OFF_CALVALID) avs_readdata <= {24'h0, calvalid_r};
      else if (avs_address == OFF_CALGAIN) avs_readdata <= calgain_r;
      else if (avs_address == OFF_STATUS)
        avs_readdata <= {24'h0, (state_r == ST_OPER), (state_r == ST_PREOP), station_r};
      else if (avs_address == OFF_DEFTX) avs_readdata <= {16'h0, defuv_r, defcnt_r};
      else avs_readdata <= 32'h0000_0000;
    end
  end

  // switches are not on core_clk: three stages, only the second reads the first
  always_ff @(posedge core_clk) begin
    stn_s1_r <= station_number;
    stn_s2_r <= stn_s1_r;
    stn_s3_r <= stn_s2_r;
  end

  // node state: bootloader, boot-up, pre-operational, operational
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r    <= ST_BOOT;
      cold_r     <= 1'b0;
      boot_cnt_r <= 64'h0;
      station_r  <= STATION_MIN;
    end else begin
      case (state_r)
        ST_BOOT: begin
          boot_cnt_r <= 64'h0;
          // straps taken once two stages agree, clamped to 1..63
          if (stn_s2_r == stn_s3_r) begin
            station_r <= (stn_s3_r < STATION_MIN) ? STATION_MIN : stn_s3_r;
            state_r <= cold_r ? ST_BOOTUP : ST_EMCY;
          end
        end
        ST_EMCY: if (tx_ready) state_r <= ST_WAIT;
        ST_WAIT: begin
          boot_cnt_r <= boot_cnt_r + 64'h1;
          if (nmt_reset || boot_cnt_r >= 64'(BOOT_CYC - 1)) begin
            cold_r  <= 1'b1;
            state_r <= ST_BOOTUP;
          end
        end
        ST_BOOTUP: if (tx_ready) state_r <= autostart_r ? ST_OPER : ST_PREOP;
        ST_PREOP, ST_OPER: begin
          // soft reset reruns init without the emergency frame or bootloader wait
          if (nmt_reset || soft_rst) state_r <= ST_BOOT;
          else if (nmt_start) state_r <= ST_OPER;
        end
        default: state_r <= ST_BOOT;
      endcase
    end
  end

  // microvolts unless uv type not sync or calibration missing
  assign use_uv = (txuv_r == TX_SYNC) && calvalid_r[adccfg_r[3:1]];
  assign uv_val = 32'(calgain_r * {16'h0, count_r});
  assign status_byte = {err_r, adccfg_r};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      scan_r  <= SC_IDLE;
      chan_r  <= 6'h00;
      count_r <= 16'h0000;
      err_r   <= 1'b0;
    end else if (state_r != ST_OPER) begin
      scan_r <= SC_IDLE;
    end else begin
      case (scan_r)
        SC_IDLE: begin
          chan_r <= 6'h00;
          if (sync_hit && chan_cnt_r != 7'h00
              && (txcnt_r == TX_SYNC || txuv_r == TX_SYNC)) scan_r <= SC_CONV;
        end
        SC_CONV: scan_r <= SC_WAIT;
        SC_WAIT: if (adc_sample.valid) begin
          count_r <= adc_sample.count;
          err_r   <= adc_sample.err;
          scan_r  <= SC_SEND;
        end
        SC_SEND: if (tx_ready) begin
          if ({1'b0, chan_r} + 7'h01 >= chan_cnt_r) scan_r <= SC_IDLE;
          else begin
            chan_r <= chan_r + 6'h01;
            scan_r <= SC_CONV;
          end
        end
        default: scan_r <= SC_IDLE;
      endcase
    end
  end

  assign adc_start = (scan_r == SC_CONV);
  assign adc_chan  = chan_r;

  // outgoing frame, held until taken
  always_comb begin
    tx_frame = '0;
    if (state_r == ST_EMCY) begin
      tx_frame.valid = 1'b1;
      tx_frame.id    = ID_EMCY + {5'h0, station_r};
      tx_frame.dlc   = 4'h8;
      tx_frame.data  = EMCY_BYTES | {48'h0, reset_cause_register, 8'h00};
    end else if (state_r == ST_BOOTUP) begin
      tx_frame.valid = 1'b1;
      tx_frame.id    = ID_BOOTUP + {5'h0, station_r};
      tx_frame.dlc   = 4'h1;
    end else if (state_r == ST_OPER && scan_r == SC_SEND) begin
      tx_frame.valid = 1'b1;
      if (use_uv) begin
        tx_frame.id   = ID_UVOLT + {5'h0, station_r};
        tx_frame.dlc  = 4'h6;
        tx_frame.data = {2'b00, chan_r, status_byte, uv_val[7:0], uv_val[15:8],
                         uv_val[23:16], uv_val[31:24], 16'h0000};
      end else begin
        tx_frame.id   = ID_COUNT + {5'h0, station_r};
        tx_frame.dlc  = 4'h4;
        tx_frame.data = {2'b00, chan_r, status_byte, count_r[7:0], count_r[15:8], 32'h0};
      end
    end
  end

  property p_no_pdo_preop;
    @(posedge core_clk) disable iff (reset)
      (tx_frame.valid && state_r != ST_OPER) |-> (tx_frame.dlc == 4'h8 || tx_frame.dlc == 4'h1);
  endproperty
  a_no_pdo_preop: assert property (p_no_pdo_preop) else $error("readout before operational");

  property p_start;
    @(posedge core_clk) disable iff (reset)
      (state_r == ST_PREOP && nmt_start && !nmt_reset && !soft_rst) |=> state_r == ST_OPER;
  endproperty
  a_start: assert property (p_start) else $error("start not honoured");

  property p_bootup_frame;
    @(posedge core_clk) disable iff (reset)
      state_r == ST_BOOTUP |-> tx_frame.valid && tx_frame.id == ID_BOOTUP + {5'h0, station_r}
                               && tx_frame.dlc == 4'h1 && tx_frame.data == 64'h0;
  endproperty
  a_bootup_frame: assert property (p_bootup_frame) else $error("bad boot-up frame");
  property p_handover;
    @(posedge core_clk) disable iff (reset)
      (state_r == ST_WAIT && nmt_reset) |=> state_r == ST_BOOTUP;
  endproperty
  a_handover: assert property (p_handover) else $error("bootloader kept control");
  // sync in operational starts a scan at channel 0
  sequence s_sync_taken;
    state_r == ST_OPER && scan_r == SC_IDLE && sync_hit && chan_cnt_r != 7'h00
    && (txcnt_r == TX_SYNC || txuv_r == TX_SYNC);
  endsequence
  sequence s_conv_first;
    adc_start && adc_chan == 6'h00;
  endsequence
  property p_sync_scan;
    @(posedge core_clk) disable iff (reset) s_sync_taken |=> s_conv_first;
  endproperty
  a_sync_scan: assert property (p_sync_scan) else $error("sync did not start a scan");
  // no conversions while waiting or pre-operational
  property p_no_scan_preop;
    @(posedge core_clk) disable iff (reset)
      (state_r == ST_WAIT || state_r == ST_PREOP) |-> !adc_start;
  endproperty
  a_no_scan_preop: assert property (p_no_scan_preop) else $error("scan outside operational");
  // both types sync with valid calibration: microvolts only
  property p_uv_only;
    @(posedge core_clk) disable iff (reset)
      (tx_frame.valid && scan_r == SC_SEND && txcnt_r == TX_SYNC && txuv_r == TX_SYNC
       && calvalid_r[adccfg_r[3:1]]) |-> tx_frame.id == ID_UVOLT + {5'h0, station_r};
  endproperty
  a_uv_only: assert property (p_uv_only) else $error("counts sent despite calibration");
endmodule : canain_node

// [shared/canain_pkg.sv]
package canain_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00; // auto-start/soft reset
  localparam logic [7:0] OFF_ADCCFG    = 8'h04; // rate, gain, polarity, channels
  localparam logic [7:0] OFF_TXTYPE    = 8'h08; // transmission types
  localparam logic [7:0] OFF_CALVALID  = 8'h0c; // per-range calibration valid
  localparam logic [7:0] OFF_CALGAIN   = 8'h10; // microvolts per count, active range
  localparam logic [7:0] OFF_STATUS    = 8'h14; // node state
  localparam logic [7:0] OFF_DEFTX     = 8'h18; // saved default transmission types
  // field positions
  localparam int CTRL_AUTOSTART_BIT = 0;
  localparam int CTRL_SOFTRST_BIT   = 1;
  // reset values
  localparam logic [6:0] CHAN_CNT_RST = 7'h40;
  localparam logic [6:0] ADCCFG_RST   = 7'h00;
  localparam logic [7:0] TXTYPE_RST   = 8'h01;
  // identifiers and message bytes
  localparam logic [10:0] ID_NMT      = 11'h000;
  localparam logic [10:0] ID_SYNC     = 11'h080;
  localparam logic [10:0] ID_EMCY     = 11'h080;
  localparam logic [10:0] ID_COUNT    = 11'h280;
  localparam logic [10:0] ID_UVOLT    = 11'h380;
  localparam logic [10:0] ID_BOOTUP   = 11'h700;
  localparam logic [7:0]  NMT_START   = 8'h01;
  localparam logic [7:0]  NMT_RESET   = 8'h81;
  localparam logic [7:0]  TX_SYNC     = 8'h01;
  localparam logic [5:0]  STATION_MIN = 6'h01;
  localparam logic [5:0]  STATION_MAX = 6'h3f;
  localparam logic [63:0] EMCY_BYTES  = 64'h0050_80fe_0128_0000;
  // bootloader timeout
  localparam longint BOOT_WAIT_MS    = 4000;
  localparam longint CLK_HZ          = 125000000;
  localparam longint BOOT_WAIT_CYC   = BOOT_WAIT_MS * CLK_HZ / 1000;

  typedef struct packed {
    logic        valid;
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data; // byte 0 in bits 63:56
  } canain_frame_type;

  typedef struct packed {
    logic        valid;
    logic [5:0]  chan;
    logic [15:0] count;
    logic        err;
  } canain_sample_type;
endpackage : canain_pkg

// [verification/canain_host_model.sv]
`timescale 1ns/100ps
// network master stand-in: sends frames to the node, takes the node's frames
module canain_host_model
  import canain_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // frames toward the node
  output canain_frame_type      rx_frame,
  // frames from the node
  input  wire canain_frame_type tx_frame,
  output logic                  tx_ready,
  input  wire logic             slow
);
  canain_frame_type got[$];

  // quiet bus at time zero
  initial begin
    rx_frame = '0;
  end

  task send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
    @(posedge core_clk);
    rx_frame <= '{1'b1, id, dlc, data};
    @(posedge core_clk);
    rx_frame <= '{1'b0, ~id, 4'h0, ~data}; // released lines scrambled, never stale
  endtask : send

  // stalls every other cycle when slow; frame taken at valid and ready
  always @(posedge core_clk) begin
    tx_ready <= reset ? 1'b0 : (slow ? ~tx_ready : 1'b1);
    if (tx_frame.valid === 1'b1 && tx_ready && !reset)
      got.push_back(tx_frame);
  end
endmodule : canain_host_model

// [verification/tb.sv]
`timescale 1ns/100ps
// bench for the analog input node
module tb;
  import canain_pkg::*;
  localparam logic [10:0] STN = 11'h005;
  logic              core_clk             = 1'b0;
  logic              reset                = 1'b1;
  logic [5:0]        station_number       = 6'h05;
  logic [7:0]        reset_cause_register = 8'h5a;
  logic [7:0]        avs_address          = 8'h00;
  logic              avs_read             = 1'b0;
  logic              avs_write            = 1'b0;
  logic [31:0]       avs_writedata        = 32'h0;
  logic              slow                 = 1'b0;
  logic [2:0]        adc_wait             = 3'h0;
  canain_sample_type adc_sample           = '0;
  logic [31:0]       avs_readdata;
  logic [31:0]       rd;
  logic              avs_waitrequest;
  logic              tx_ready;
  logic              adc_start;
  logic [5:0]        adc_chan;
  logic [5:0]        ach;
  canain_frame_type  rx_frame;
  canain_frame_type  tx_frame;
  int                n_errors = 0;
  int                checks   = 0;

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  canain_node #(.BOOT_CYC(2000)) u_dut (.core_clk(core_clk), .reset(reset),
    .station_number(station_number), .reset_cause_register(reset_cause_register),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_frame(rx_frame), .tx_frame(tx_frame),
    .tx_ready(tx_ready), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_sample(adc_sample));

  canain_host_model u_host (.core_clk(core_clk), .reset(reset), .rx_frame(rx_frame),
    .tx_frame(tx_frame), .tx_ready(tx_ready), .slow(slow));

  // adc stand-in: answers three cycles after a start; count scrambled when idle
  always @(posedge core_clk) begin
    adc_sample.valid <= 1'b0;
    adc_sample.count <= ~adc_sample.count;
    if (adc_start === 1'b1) begin
      adc_wait <= 3'h3;
      ach      <= adc_chan;
    end else if (adc_wait != 3'h0) begin
      adc_wait <= adc_wait - 3'h1;
      if (adc_wait == 3'h1)
        adc_sample <= '{1'b1, ach, 16'h0a00 + {10'h0, ach}, ach[0]};
    end
  end

  task final_report;
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task chk_reg(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t reg exp %h got %h", $time, exp, got);
    end
  endtask : chk_reg

  // one avalon access, held until waitrequest is sampled low
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av

  // next frame taken by the host; only the dlc bytes are compared
  task exp_frame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d,
                 input int lim);
    logic [63:0]      m;
    canain_frame_type f;
    m = ~(64'hffff_ffff_ffff_ffff >> {dlc, 3'b000});
    f = '0;
    repeat (lim) if (u_host.got.size() == 0) @(posedge core_clk);
    if (u_host.got.size() != 0) f = u_host.got.pop_front();
    checks++;
    if ({f.valid, f.id, f.dlc, f.data & m} !== {1'b1, id, dlc, d & m}) begin
      n_errors++;
      $display("ERROR %0t frame exp %h got %h", $time, {id, dlc, d}, {f.id, f.dlc, f.data});
    end
  endtask : exp_frame

  task exp_none(input int n);
    repeat (n) @(posedge core_clk);
    chk_reg(32'h0, 32'(u_host.got.size()));
  endtask : exp_none

  // three-channel scan, configuration byte 2a, odd channels flagged in error
  task scan(input logic uv, input logic [31:0] g);
    logic [15:0] c;
    logic [31:0] v;
    for (int ch = 0; ch < 3; ch++) begin
      c = 16'h0a00 + 16'(ch);
      v = {16'h0, c} * g;
      if (uv)
        exp_frame(ID_UVOLT + STN, 4'h6,
          {8'(ch), ch[0], 7'h2a, v[7:0], v[15:8], v[23:16], v[31:24], 16'h0}, 3000);
      else
        exp_frame(ID_COUNT + STN, 4'h4, {8'(ch), ch[0], 7'h2a, c[7:0], c[15:8], 32'h0}, 3000);
    end
  endtask : scan

  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    exp_frame(11'h085, 4'h8, {32'h0050_80fe, 32'h0128_5a00}, 100);
    u_host.send(ID_NMT, 4'h2, {NMT_RESET, 8'h05, 48'h0});
    exp_frame(ID_BOOTUP + STN, 4'h1, 64'h0, 200);
    av(1'b0, OFF_STATUS, 32'h0);
    chk_reg(32'h0000_0045, rd);
    av(1'b0, OFF_TXTYPE, 32'h0);
    chk_reg(32'h0000_0101, rd);
    av(1'b0, 8'h40, 32'h0);
    chk_reg(32'h0, rd);
    av(1'b1, OFF_ADCCFG, 32'h0000_642a);
    av(1'b0, OFF_ADCCFG, 32'h0);
    chk_reg(32'h0000_402a, rd);
    av(1'b1, OFF_ADCCFG, 32'h0000_032a);
    u_host.send(ID_SYNC, 4'h0, 64'h0);
    exp_none(100);
    u_host.send(ID_NMT, 4'h2, {NMT_START, 56'h0});
    exp_none(50);
    av(1'b0, OFF_STATUS, 32'h0);
    chk_reg(32'h0000_0085, rd);
    slow <= 1'b1;
    u_host.send(ID_SYNC, 4'h0, 64'h0);
    scan(1'b0, 32'h0);
    slow <= 1'b0;
    exp_none(100);
    av(1'b1, OFF_CALVALID, 32'h0000_0020);
    av(1'b1, OFF_CALGAIN, 32'h0000_0003);
    u_host.send(ID_SYNC, 4'h0, 64'h0);
    scan(1'b1, 32'h3);
    av(1'b1, OFF_TXTYPE, 32'h0000_0001);
    u_host.send(ID_SYNC, 4'h0, 64'h0);
    scan(1'b0, 32'h0);
    av(1'b1, OFF_DEFTX, 32'h0000_0001);
    av(1'b1, OFF_CTRL, 32'h0000_0001);
    u_host.send(ID_NMT, 4'h2, {NMT_RESET, 8'h05, 48'h0});
    exp_frame(ID_BOOTUP + STN, 4'h1, 64'h0, 3000);
    av(1'b0, OFF_STATUS, 32'h0);
    chk_reg(32'h0000_0085, rd);
    av(1'b0, OFF_TXTYPE, 32'h0);
    chk_reg(32'h0000_0001, rd);
    av(1'b1, OFF_CTRL, 32'h0000_0002);
    exp_frame(ID_BOOTUP + STN, 4'h1, 64'h0, 200);
    av(1'b0, OFF_STATUS, 32'h0);
    chk_reg(32'h0000_0045, rd);
    final_report;
  end

  // hang guard, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    final_report;
  end
endmodule : tb
